// >>> pkg/rtcs_pkg.sv
// rtcs_pkg: constants shared by both ends of the three-wire clock link.
// assumes a 10 MHz system clock on each end.
package rtcs_pkg;
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          ADDR_W          = 4;
	localparam int          BYTE_W          = 8;
	localparam int          BIT_CNT_W       = 3;
	// command byte layout
	localparam int          CMD_ADDR_LSB    = 4;
	localparam int          FMT_SINGLE_BIT  = 3;
	localparam int          FMT_READ_BIT    = 2;
	localparam logic [1:0]  FMT_LOW_ZERO    = 2'h0;
	// transfer format codes
	localparam logic [3:0]  FMT_WR_SINGLE   = 4'h8;
	localparam logic [3:0]  FMT_WR_BURST    = 4'h0;
	localparam logic [3:0]  FMT_RD_SINGLE   = 4'hc;
	localparam logic [3:0]  FMT_RD_BURST    = 4'h4;
	localparam logic [3:0]  FMT_RESET       = FMT_WR_SINGLE;
	localparam logic [3:0]  ADDR_RESET      = 4'h0;
	// session timing
	localparam int          SETUP_NS        = 31000;
	localparam int          GAP_NS          = 61000;
	localparam int          SESSION_MAX_NS  = 1000000000;
	localparam int          SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          GAP_CYC         = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SESSION_MAX_CYC = SESSION_MAX_NS / CLK_PERIOD_NS;
	localparam int          LINK_HALF_CYC   = 4;
	localparam int          TIMER_W         = 16;
	localparam int          SESS_W          = 24;
	typedef enum logic [2:0] {
		HS_IDLE,
		HS_SETUP,
		HS_START,
		HS_BIT_HI,
		HS_BIT_LO,
		HS_HOLD
	} rtcs_host_state_e;
endpackage : rtcs_pkg

// >>> pkg/rtcs_link_if.sv
// rtcs_link_if: select, serial clock and shared data line of the link.
// assumes a pull-up on the data line when neither end drives it.
`timescale 1ns/1ns
`default_nettype none
interface rtcs_link_if;
	logic sel;
	logic sclk;
	logic hostDataOut;
	logic hostDataOe;
	logic devDataOut;
	logic devDataOe;
	logic dataIoLine;

	assign dataIoLine = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : 1'b1);

	modport host (
		output sel,
		output sclk,
		output hostDataOut,
		output hostDataOe,
		input  dataIoLine
	);
	modport device (
		input  sel,
		input  sclk,
		input  dataIoLine,
		output devDataOut,
		output devDataOe
	);
endinterface : rtcs_link_if
`default_nettype wire

// >>> src/rtcs_device.sv
// rtcs_device: serial slave end of the clock chip's three-wire port.
// assumes the clock core holds regRdData stable while carryHold is high.
`timescale 1ns/1ns
`default_nettype none
module rtcs_device
	import rtcs_pkg::*;
(
	// system side
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                clockEn,
	// link
	rtcs_link_if.device              link,
	// clock core register port
	output logic      [ADDR_W-1:0]   regAddr,
	input  wire logic [BYTE_W-1:0]   regRdData,
	output logic                     regWrStrobe,
	output logic      [ADDR_W-1:0]   regWrAddr,
	output logic      [BYTE_W-1:0]   regWrData,
	// carry hold
	output logic                     carryHold,
	input  wire logic                secTick,
	output logic                     secTickOut
);

	////////////////////////////////////////////////////////////////////////
	// system domain: select and clock level synchronisers

	logic selS1_q;
	logic selS2_q;
	logic selPrev_q;
	logic sclkS1_q;
	logic sclkS2_q;
	logic modeHigh_q;
	logic sessOn_q;
	logic rstHeld_q;
	logic selRise;

	always_ff @(posedge clock) begin
		if (rst) begin
			selS1_q   <= 1'b0;
			selS2_q   <= 1'b0;
			selPrev_q <= 1'b0;
			sclkS1_q  <= 1'b0;
			sclkS2_q  <= 1'b0;
		end else if (clockEn) begin
			selS1_q   <= link.sel;
			selS2_q   <= selS1_q;
			selPrev_q <= selS2_q;
			sclkS1_q  <= link.sclk;
			sclkS2_q  <= sclkS1_q;
		end
	end

	assign selRise = selS2_q & ~selPrev_q;

	// edge mode caught at select rise while the serial clock is idle
	always_ff @(posedge clock) begin
		if (rst) begin
			modeHigh_q <= 1'b0;
		end else if (clockEn && selRise) begin
			modeHigh_q <= sclkS2_q;
		end
	end

	// session opens one cycle after the mode settles, so the
	// edge that the mode change may put on the sample clock is
	// swallowed by the clear
	always_ff @(posedge clock) begin
		if (rst) begin
			sessOn_q <= 1'b0;
		end else if (clockEn) begin
			sessOn_q <= selS2_q & selPrev_q;
		end
	end

	always_ff @(posedge clock) begin
		rstHeld_q <= rst;
	end

	////////////////////////////////////////////////////////////////////////
	// carry hold toward the time counters

	logic secPend_q;
	logic secOut_q;

	assign carryHold  = selS2_q;
	assign secTickOut = secOut_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			secPend_q <= 1'b0;
			secOut_q  <= 1'b0;
		end else if (clockEn) begin
			if (selS2_q) begin
				// a second tick while pending means the hold ran
				// out: let the old carry go, keep the new one
				secOut_q  <= secTick & secPend_q;
				secPend_q <= secTick | secPend_q;
			end else begin
				secOut_q  <= secTick | secPend_q;
				secPend_q <= secTick & secPend_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: sample and output clocks

	logic outClk;
	logic sampClk;
	logic linkClr;

	// mode low: drive on rising, sample on falling; mode high: reverse
	assign outClk  = link.sclk ^ modeHigh_q;
	assign sampClk = ~outClk;
	assign linkClr = ~sessOn_q;

	logic [BIT_CNT_W-1:0] bitCnt_q;
	logic [BYTE_W-2:0]    shift_q;
	logic                 inData_q;
	logic [3:0]           fmt_q;
	logic [ADDR_W-1:0]    ptr_q;
	logic [BYTE_W-1:0]    rxByte;
	logic                 byteDone;
	logic                 fmtValid;
	logic                 fmtRead;
	logic                 fmtSingle;

	assign rxByte    = {shift_q, link.dataIoLine};
	assign byteDone  = (bitCnt_q == BIT_CNT_W'(BYTE_W - 1));
	assign fmtValid  = (fmt_q[1:0] == FMT_LOW_ZERO);
	assign fmtRead   = fmt_q[FMT_READ_BIT];
	assign fmtSingle = fmt_q[FMT_SINGLE_BIT];

	always_ff @(posedge sampClk or posedge linkClr) begin
		if (linkClr) begin
			bitCnt_q <= '0;
			shift_q  <= '0;
			inData_q <= 1'b0;
			fmt_q    <= FMT_RESET;
			ptr_q    <= ADDR_RESET;
		end else begin
			bitCnt_q <= bitCnt_q + 1'b1;
			shift_q  <= rxByte[BYTE_W-2:0];
			if (byteDone) begin
				if (!inData_q) begin
					ptr_q    <= rxByte[BYTE_W-1:CMD_ADDR_LSB];
					fmt_q    <= rxByte[CMD_ADDR_LSB-1:0];
					inData_q <= 1'b1;
				end else if (fmtSingle || !fmtValid) begin
					inData_q <= 1'b0;
				end else begin
					ptr_q <= ptr_q + 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write capture; survives the session clear so a write that
	// completes just before select falls still reaches the core

	logic                 wrTog_q;
	logic [ADDR_W-1:0]    wrAddr_q;
	logic [BYTE_W-1:0]    wrData_q;

	always_ff @(posedge sampClk or posedge rstHeld_q) begin
		if (rstHeld_q) begin
			wrTog_q  <= 1'b0;
			wrAddr_q <= ADDR_RESET;
			wrData_q <= '0;
		end else if (byteDone && inData_q && !fmtRead && fmtValid) begin
			wrAddr_q <= ptr_q;
			wrData_q <= rxByte;
			wrTog_q  <= ~wrTog_q;
		end
	end

	assign regWrAddr = wrAddr_q;
	assign regWrData = wrData_q;

	logic wrS1_q;
	logic wrS2_q;
	logic wrS3_q;
	logic wrStb_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			wrS1_q  <= 1'b0;
			wrS2_q  <= 1'b0;
			wrS3_q  <= 1'b0;
			wrStb_q <= 1'b0;
		end else if (clockEn) begin
			wrS1_q  <= wrTog_q;
			wrS2_q  <= wrS1_q;
			wrS3_q  <= wrS2_q;
			wrStb_q <= wrS2_q ^ wrS3_q;
		end
	end

	assign regWrStrobe = wrStb_q;

	////////////////////////////////////////////////////////////////////////
	// read data out on the output edge

	logic oe_q;
	logic dout_q;

	assign regAddr = ptr_q;

	always_ff @(posedge outClk or posedge linkClr) begin
		if (linkClr) begin
			oe_q   <= 1'b0;
			dout_q <= 1'b0;
		end else begin
			oe_q   <= inData_q & fmtRead & fmtValid;
			dout_q <= regRdData[BIT_CNT_W'(BYTE_W - 1) - bitCnt_q];
		end
	end

	assign link.devDataOut = dout_q;
	assign link.devDataOe  = oe_q & link.sel;

endmodule : rtcs_device
`default_nettype wire

// >>> src/rtcs_host.sv
// rtcs_host: controller end of the three-wire clock link.
// assumes the user holds wrData valid whenever wrTake may pulse.
`timescale 1ns/1ns
`default_nettype none
module rtcs_host
	import rtcs_pkg::*;
#(
	parameter int   HALF_CYC      = LINK_HALF_CYC,
	parameter int   SESSION_LIMIT = SESSION_MAX_CYC,
	parameter logic IDLE_HIGH     = 1'b0,
	parameter int   LEN_W         = 8
) (
	// system side
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              clockEn,
	// link
	rtcs_link_if.host              link,
	// requests
	input  wire logic              reqValid,
	output logic                   reqReady,
	input  wire logic [BYTE_W-1:0] reqCmd,
	input  wire logic [LEN_W-1:0]  reqLen,
	input  wire logic              reqKeep,
	input  wire logic              endSession,
	// data
	input  wire logic [BYTE_W-1:0] wrData,
	output logic                   wrTake,
	output logic      [BYTE_W-1:0] rdData,
	output logic                   rdValid,
	output logic                   done
);

	localparam logic [TIMER_W-1:0] SETUP_T = TIMER_W'(SETUP_CYC - 1);
	localparam logic [TIMER_W-1:0] HALF_T  = TIMER_W'(HALF_CYC - 1);
	localparam logic [TIMER_W-1:0] GAP_T   = TIMER_W'(GAP_CYC);
	localparam logic [SESS_W-1:0]  SESS_T  = SESS_W'(SESSION_LIMIT - 1);

	rtcs_host_state_e     state_q;
	logic                 sel_q;
	logic                 sclk_q;
	logic                 oe_q;
	logic                 dout_q;
	logic [TIMER_W-1:0]   timer_q;
	logic [TIMER_W-1:0]   gap_q;
	logic [SESS_W-1:0]    sess_q;
	logic [2:0]           bitCnt_q;
	logic [LEN_W-1:0]     left_q;
	logic                 isRead_q;
	logic                 inCmd_q;
	logic                 keep_q;
	logic [BYTE_W-1:0]    tx_q;
	logic [BYTE_W-1:0]    rx_q;
	logic                 dinS1_q;
	logic                 dinS2_q;
	logic                 gapDone;
	logic [LEN_W-1:0]     nextLeft;

	////////////////////////////////////////////////////////////////////////
	// data line synchroniser and session timers

	always_ff @(posedge clock) begin
		if (rst) begin
			dinS1_q <= 1'b1;
			dinS2_q <= 1'b1;
		end else if (clockEn) begin
			dinS1_q <= link.dataIoLine;
			dinS2_q <= dinS1_q;
		end
	end

	// gap timer starts full so the first session may open at once
	always_ff @(posedge clock) begin
		if (rst) begin
			gap_q  <= GAP_T;
			sess_q <= '0;
		end else if (clockEn) begin
			if (sel_q) begin
				gap_q  <= '0;
				sess_q <= sess_q + 1'b1;
			end else begin
				sess_q <= '0;
				if (!gapDone) begin
					gap_q <= gap_q + 1'b1;
				end
			end
		end
	end

	assign gapDone  = (gap_q == GAP_T);
	assign reqReady = ((state_q == HS_IDLE) && gapDone) || (state_q == HS_HOLD);
	assign nextLeft = inCmd_q ? left_q : left_q - 1'b1;

	////////////////////////////////////////////////////////////////////////
	// transfer sequencer

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q  <= HS_IDLE;
			sel_q    <= 1'b0;
			sclk_q   <= IDLE_HIGH;
			oe_q     <= 1'b0;
			dout_q   <= 1'b0;
			timer_q  <= '0;
			bitCnt_q <= '0;
			left_q   <= '0;
			isRead_q <= 1'b0;
			inCmd_q  <= 1'b0;
			keep_q   <= 1'b0;
			tx_q     <= '0;
			rx_q     <= '0;
			rdData   <= '0;
			rdValid  <= 1'b0;
			wrTake   <= 1'b0;
			done     <= 1'b0;
		end else if (clockEn) begin
			rdValid <= 1'b0;
			wrTake  <= 1'b0;
			done    <= 1'b0;
			case (state_q)
				HS_IDLE, HS_HOLD: begin
					if (reqValid && reqReady) begin
						tx_q     <= reqCmd;
						left_q   <= reqLen;
						isRead_q <= reqCmd[FMT_READ_BIT];
						keep_q   <= reqKeep;
						inCmd_q  <= 1'b1;
						bitCnt_q <= '0;
						timer_q  <= SETUP_T;
						// a chained command needs no fresh setup wait
						state_q  <= sel_q ? HS_START : HS_SETUP;
						sel_q    <= 1'b1;
					end else if (state_q == HS_HOLD && (endSession || sess_q >= SESS_T)) begin
						sel_q   <= 1'b0;
						state_q <= HS_IDLE;
					end
				end
				HS_SETUP: begin
					if (timer_q == '0) begin
						state_q <= HS_START;
					end else begin
						timer_q <= timer_q - 1'b1;
					end
				end
				HS_START: begin
					sclk_q  <= ~IDLE_HIGH;
					oe_q    <= inCmd_q | ~isRead_q;
					dout_q  <= tx_q[BYTE_W-1];
					timer_q <= HALF_T;
					state_q <= HS_BIT_HI;
				end
				HS_BIT_HI: begin
					if (timer_q == '0) begin
						sclk_q  <= IDLE_HIGH;
						rx_q    <= {rx_q[BYTE_W-2:0], dinS2_q};
						tx_q    <= {tx_q[BYTE_W-2:0], 1'b0};
						timer_q <= HALF_T;
						state_q <= HS_BIT_LO;
					end else begin
						timer_q <= timer_q - 1'b1;
					end
				end
				HS_BIT_LO: begin
					if (timer_q != '0) begin
						timer_q <= timer_q - 1'b1;
					end else if (bitCnt_q != 3'h7) begin
						bitCnt_q <= bitCnt_q + 1'b1;
						state_q  <= HS_START;
					end else begin
						bitCnt_q <= '0;
						inCmd_q  <= 1'b0;
						left_q   <= nextLeft;
						if (!inCmd_q && isRead_q) begin
							rdData  <= rx_q;
							rdValid <= 1'b1;
						end
						if (nextLeft == '0) begin
							oe_q    <= 1'b0;
							done    <= 1'b1;
							sel_q   <= keep_q;
							state_q <= keep_q ? HS_HOLD : HS_IDLE;
						end else begin
							if (!isRead_q) begin
								tx_q   <= wrData;
								wrTake <= 1'b1;
							end
							state_q <= HS_START;
						end
					end
				end
				default: begin
					state_q <= HS_IDLE;
				end
			endcase
		end
	end

	assign link.sel         = sel_q;
	assign link.sclk        = sclk_q;
	assign link.hostDataOut = dout_q;
	assign link.hostDataOe  = oe_q;

endmodule : rtcs_host
`default_nettype wire

// >>> sim/rtcs_link_properties.sv
// rtcs_link_properties: timing checks on the shared three-wire link.
// assumes the host idles sclk low and both ends share the system clock.
`timescale 1ns/1ns
`default_nettype none
module rtcs_link_properties
	import rtcs_pkg::*;
#(
	parameter int SESSION_LIMIT = SESSION_MAX_CYC
) (
	// system
	input wire logic clock,
	input wire logic rst,
	// link
	input wire logic sel,
	input wire logic sclk,
	input wire logic hostDataOe,
	input wire logic devDataOut,
	input wire logic devDataOe
);
	logic [SESS_W-1:0]  hiCnt_q;
	logic [TIMER_W-1:0] loCnt_q;
	logic [2:0]         bitCnt_q;
	logic               sclk_q;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (rst || !sel)
			hiCnt_q <= '0;
		else
			hiCnt_q <= hiCnt_q + 1'b1;
	end
	// starts full, as the host's gap timer does
	always_ff @(posedge clock) begin
		if (rst)
			loCnt_q <= TIMER_W'(GAP_CYC);
		else if (sel)
			loCnt_q <= '0;
		else if (loCnt_q != '1)
			loCnt_q <= loCnt_q + 1'b1;
	end
	always_ff @(posedge clock) begin
		sclk_q <= sclk;
	end
	// wraps every byte, so zero marks a byte boundary
	always_ff @(posedge clock) begin
		if (rst || !sel)
			bitCnt_q <= '0;
		else if (sclk && !sclk_q)
			bitCnt_q <= bitCnt_q + 1'b1;
	end
	////////////////////////////////////////
	property p_idle_off; !sel |-> !devDataOe; endproperty
	a_idle_off: assert property (p_idle_off) else $error("device drives idle link");
	property p_one_drv; !(devDataOe && hostDataOe); endproperty
	a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
	property p_clk_idle; !sel |-> !sclk; endproperty
	a_clk_idle: assert property (p_clk_idle) else $error("sclk active outside session");
	property p_setup; $rose(sclk) |-> hiCnt_q >= SETUP_CYC - 2; endproperty
	a_setup: assert property (p_setup) else $error("sclk too soon after select");
	property p_gap; $rose(sel) |-> loCnt_q >= GAP_CYC - 2; endproperty
	a_gap: assert property (p_gap) else $error("select low gap too short");
	property p_limit; sel |-> hiCnt_q < SESSION_LIMIT; endproperty
	a_limit: assert property (p_limit) else $error("session too long");
	property p_byte_end; $fell(sel) |-> bitCnt_q == 3'h0; endproperty
	a_byte_end: assert property (p_byte_end) else $error("session ends mid byte");
	property p_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
	a_half: assert property (p_half) else $error("sclk high phase wrong");
	property p_dev_edge;
		$changed(devDataOut) && devDataOe && $past(devDataOe) |-> $rose(sclk);
	endproperty
	a_dev_edge: assert property (p_dev_edge) else $error("read data off output edge");
	property p_rd_start; $rose(devDataOe) |-> $rose(sclk) && bitCnt_q == 3'h0; endproperty
	a_rd_start: assert property (p_rd_start) else $error("read drive off byte start");
endmodule : rtcs_link_properties
`default_nettype wire

// >>> sim/rtcs_three_wire_tb.sv
// rtcs_three_wire_tb: host and device ends joined over the link interface.
// assumes one 10 MHz clock for both ends; the bench models the clock core.
`timescale 1ns/1ns
`default_nettype none
module three_wire_rtc_serial_access_tb
	import rtcs_pkg::*;
;
	localparam int LIMIT = 2000;
	logic              clock, rst, reqValid, reqReady, reqKeep, endSession;
	logic              wrTake, rdValid, done, regWrStrobe, carryHold, secTick, secTickOut;
	logic [BYTE_W-1:0] reqCmd, reqLen, wrData, rdData, regRdData, regWrData, sh;
	logic [ADDR_W-1:0] regAddr, regWrAddr;
	logic [BYTE_W-1:0] mem [16];
	logic [BYTE_W-1:0] wq [$], rq [$], wb [$];
	int                error_cnt, checks, bc, ticks;

	rtcs_link_if i_rtcs_link_if ();
	rtcs_host #(.SESSION_LIMIT(LIMIT)) i_rtcs_host (
		.clock(clock), .rst(rst), .clockEn(1'b1), .link(i_rtcs_link_if.host),
		.reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .reqLen(reqLen),
		.reqKeep(reqKeep), .endSession(endSession), .wrData(wrData), .wrTake(wrTake),
		.rdData(rdData), .rdValid(rdValid), .done(done)
	);
	rtcs_device i_rtcs_device (
		.clock(clock), .rst(rst), .clockEn(1'b1), .link(i_rtcs_link_if.device),
		.regAddr(regAddr), .regRdData(regRdData), .regWrStrobe(regWrStrobe),
		.regWrAddr(regWrAddr), .regWrData(regWrData), .carryHold(carryHold),
		.secTick(secTick), .secTickOut(secTickOut)
	);
	rtcs_link_properties #(.SESSION_LIMIT(LIMIT)) i_rtcs_link_properties (
		.clock(clock), .rst(rst), .sel(i_rtcs_link_if.sel), .sclk(i_rtcs_link_if.sclk),
		.hostDataOe(i_rtcs_link_if.hostDataOe), .devDataOut(i_rtcs_link_if.devDataOut),
		.devDataOe(i_rtcs_link_if.devDataOe)
	);
	////////////////////////////////////////
	// clock core: reads combinational, writes on the strobe
	assign regRdData = mem[regAddr];
	always @(posedge clock) begin
		if (regWrStrobe === 1'b1)
			mem[regWrAddr] <= regWrData;
		if (secTickOut === 1'b1)
			ticks <= ticks + 1;
	end
	// bytes as seen on the wire at the sample edge, cleared per session
	always @(posedge i_rtcs_link_if.sel) begin
		wb.delete();
		bc = 0;
	end
	always @(negedge i_rtcs_link_if.sclk) begin
		if (i_rtcs_link_if.sel === 1'b1) begin
			sh = {sh[6:0], i_rtcs_link_if.dataIoLine};
			bc++;
			if (bc % 8 == 0)
				wb.push_back(sh);
		end
	end
	////////////////////////////////////////
	task automatic close_out();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : cmp

	// waits first, since a held seconds carry reaches the core a few clocks after done; the write lands with done
	task automatic chk(input logic [7:0] e [$], input logic [7:0] q [$]);
		repeat (8) @(negedge clock);
		cmp(8'(q.size()), 8'(e.size()));
		foreach (e[i])
			cmp(q[i], e[i]);
	endtask : chk

	// one host request; tk drops a seconds tick into the session
	task automatic xfer(input logic [7:0] cmd, input int n, input logic keep, input logic tk);
		int k;
		@(negedge clock);
		reqCmd = cmd;
		reqLen = 8'(n);
		reqKeep = keep;
		if (wq.size() > 0)
			wrData = wq[0];
		reqValid = 1'b1;
		for (k = 0; k < 2000 && reqReady !== 1'b1; k++)
			@(negedge clock);
		@(negedge clock);
		reqValid = 1'b0;
		if (tk)
			fork
				begin
					repeat (400) @(negedge clock);
					secTick = 1'b1;
					cmp({7'h0, carryHold}, 8'h01);
					@(negedge clock);
					secTick = 1'b0;
				end
			join_none
		for (k = 0; k < 4000; k++) begin
			@(negedge clock);
			if (wrTake === 1'b1)
				void'(wq.pop_front());
			if (wq.size() > 0)
				wrData = wq[0];
			if (rdValid === 1'b1)
				rq.push_back(rdData);
			if (done === 1'b1)
				break;
		end
	endtask : xfer

	task automatic end_sess();
		int k;
		@(negedge clock);
		endSession = 1'b1;
		for (k = 0; k < 100 && i_rtcs_link_if.sel !== 1'b0; k++)
			@(negedge clock);
		endSession = 1'b0;
	endtask : end_sess
	////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (40000) @(posedge clock);
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
	initial begin
		{rst, reqValid, reqKeep, endSession, secTick} = 5'h10;
		{reqCmd, reqLen, wrData} = '0;
		{error_cnt, checks, bc, ticks} = '0;
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (16) @(negedge clock);
		rst = 1'b0;
		// chained single writes, closed from the hold state
		wq = '{8'ha5, 8'h3c};
		xfer(8'hf8, 1, 1'b1, 1'b0);
		xfer(8'h78, 1, 1'b1, 1'b0);
		end_sess();
		chk('{8'hf8, 8'ha5, 8'h78, 8'h3c}, wb);
		cmp(mem[4'hf], 8'ha5);
		cmp(mem[4'h7], 8'h3c);
		// burst write across the wrap; 28h would read as a command
		wq = '{8'h11, 8'h22, 8'h28, 8'h33};
		xfer(8'he0, 4, 1'b0, 1'b0);
		chk('{8'he0, 8'h11, 8'h22, 8'h28, 8'h33}, wb);
		cmp(mem[4'he], 8'h11);
		cmp(mem[4'h0], 8'h28);
		cmp(mem[4'h1], 8'h33);
		cmp(mem[4'h2], 8'h00);
		// chained single reads
		xfer(8'hec, 1, 1'b1, 1'b0);
		xfer(8'h7c, 1, 1'b0, 1'b0);
		chk('{8'hec, 8'h11, 8'h7c, 8'h3c}, wb);
		chk('{8'h11, 8'h3c}, rq);
		// burst read across the wrap, seconds tick held meanwhile
		rq.delete();
		ticks = 0;
		xfer(8'hf4, 3, 1'b0, 1'b1);
		cmp(8'(ticks), 8'h00);
		chk('{8'h22, 8'h28, 8'h33}, rq);
		cmp(8'(ticks), 8'h01);
		// read, write, then a burst to close the chain
		rq.delete();
		wq = '{8'h5a};
		xfer(8'hfc, 1, 1'b1, 1'b0);
		xfer(8'hf8, 1, 1'b1, 1'b0);
		xfer(8'hf4, 2, 1'b0, 1'b0);
		chk('{8'h22, 8'h5a, 8'h28}, rq);
		close_out();
	end
endmodule : three_wire_rtc_serial_access_tb
`default_nettype wire
